// >>> bench/t2cf_cpu_model.sv
// t2cf_cpu_model: cpu side of the sfr bus, byte, bit and read cycles
// assumes registered read data one cycle after the address is presented
`timescale 1ns/1ps
module t2cf_cpu_model
  import t2cf_pkg::*;
(
  // clock
  input  wire logic          mclk,
  // sfr bus
  input  wire logic    [7:0] sfr_rdata_r,
  output t2cf_sfr_req_t      sfr_req
);
  initial begin
    sfr_req = '0;
  end
  // ==========================================================================
  // bus cycles, driven on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_req.wr    <= 1'b1;
    sfr_req.addr  <= a;
    sfr_req.wdata <= d;
    @(negedge mclk);
    sfr_req.wr    <= 1'b0;
  endtask
  task automatic wr_bit(input logic [2:0] idx, input logic b);
    @(negedge mclk);
    sfr_req.bit_wr  <= 1'b1;
    sfr_req.addr    <= T2CF_ADDR_CTRL;
    sfr_req.bit_idx <= idx;
    sfr_req.wdata   <= {7'h00, b};
    @(negedge mclk);
    sfr_req.bit_wr  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_req.addr <= a;
    @(negedge mclk);
    d = sfr_rdata_r;
  endtask
endmodule // t2cf_cpu_model

// >>> bench/timer2_control_flags_tb.sv
// timer2_control_flags_tb: self-checking bench for the timer 2 flag block
// assumes t2cf_top and the cpu model; inputs change on the falling edge
`timescale 1ns/1ps
module timer2_control_flags_tb;
  import t2cf_pkg::*;
  logic          mclk, nrst, tick_hi, tick_lo, capture_evt, cpu_en, irq;
  logic    [7:0] rdata, v;
  logic    [1:0] xclk;
  t2cf_sfr_req_t sfr_req;
  int            fails, checked;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  t2cf_top t2cf_top_i (.mclk(mclk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata_r(rdata),
    .tick_hi(tick_hi), .tick_lo(tick_lo), .capture_evt(capture_evt),
    .cpu_timer_irq_en(cpu_en), .irq_r(irq), .external_clock_select_r(xclk));
  t2cf_cpu_model t2cf_cpu_model_i (.mclk(mclk), .sfr_rdata_r(rdata), .sfr_req(sfr_req));
  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] exp);
    t2cf_cpu_model_i.rd(a, v);
    chk(n, v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    t2cf_cpu_model_i.wr(a, d);
  endtask
  task automatic pulse(input int which);
    @(negedge mclk);
    if (which == 0) tick_lo <= 1'b1; else if (which == 1) tick_hi <= 1'b1;
    else capture_evt <= 1'b1;
    @(negedge mclk);
    {tick_lo, tick_hi, capture_evt} <= 3'b000;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rc("ctrl reset", T2CF_ADDR_CTRL, 8'h00_00);
    rc("unmapped", 8'h00_C9, 8'h00_00);
    wr(T2CF_ADDR_CTRL, 8'h00_03);
    rc("ctrl clksel", T2CF_ADDR_CTRL, 8'h00_03);
    chk("clksel out", {6'h00, xclk}, 8'h00_03);
    $display("test reset done");
  endtask
  task automatic t_wrap16();
    wr(T2CF_ADDR_RLH, 8'h00_12);
    wr(T2CF_ADDR_RLL, 8'h00_34);
    wr(T2CF_ADDR_CNTH, 8'h00_FF);
    wr(T2CF_ADDR_CNTL, 8'h00_FE);
    wr(T2CF_ADDR_CTRL, 8'h00_04);
    pulse(0);
    rc("ctrl no wrap", T2CF_ADDR_CTRL, 8'h00_04);
    pulse(0);
    rc("ctrl wrap", T2CF_ADDR_CTRL, 8'h00_C4);
    rc("reload lo", T2CF_ADDR_CNTL, 8'h00_34);
    rc("reload hi", T2CF_ADDR_CNTH, 8'h00_12);
    chk("irq high", {7'h00, irq}, 8'h00_01);
    t2cf_cpu_model_i.wr_bit(T2CF_BIT_HOVF_IDX, 1'b0);
    rc("ctrl cleared", T2CF_ADDR_CTRL, 8'h00_44);
    chk("irq lo masked", {7'h00, irq}, 8'h00_00);
    wr(T2CF_ADDR_CTRL, 8'h00_64);
    rc("ctrl lien", T2CF_ADDR_CTRL, 8'h00_64);
    chk("irq lo", {7'h00, irq}, 8'h00_01);
    cpu_en = 1'b0;
    rc("ctrl hold", T2CF_ADDR_CTRL, 8'h00_64);
    chk("irq cpu off", {7'h00, irq}, 8'h00_00);
    cpu_en = 1'b1;
    $display("test wrap16 done");
  endtask
  task automatic t_split();
    wr(T2CF_ADDR_CTRL, 8'h00_08);
    wr(T2CF_ADDR_CNTH, 8'h00_FF);
    wr(T2CF_ADDR_CNTL, 8'h00_FF);
    pulse(1);
    pulse(0);
    rc("split ctrl", T2CF_ADDR_CTRL, 8'h00_48);
    rc("split hi", T2CF_ADDR_CNTH, 8'h00_FF);
    rc("split lo", T2CF_ADDR_CNTL, 8'h00_34);
    wr(T2CF_ADDR_CNTL, 8'h00_FF);
    fork
      pulse(0);
      wr(T2CF_ADDR_CTRL, 8'h00_08);
    join
    rc("set wins", T2CF_ADDR_CTRL, 8'h00_48);
    wr(T2CF_ADDR_CTRL, 8'h00_4C);
    pulse(1);
    rc("split run ctrl", T2CF_ADDR_CTRL, 8'h00_CC);
    rc("split run hi", T2CF_ADDR_CNTH, 8'h00_12);
    $display("test split done");
  endtask
  task automatic t_capture();
    wr(T2CF_ADDR_CTRL, 8'h00_10);
    wr(T2CF_ADDR_CNTH, 8'h00_AB);
    wr(T2CF_ADDR_CNTL, 8'h00_CD);
    pulse(2);
    rc("cap ctrl", T2CF_ADDR_CTRL, 8'h00_90);
    rc("cap rlh", T2CF_ADDR_RLH, 8'h00_AB);
    rc("cap rll", T2CF_ADDR_RLL, 8'h00_CD);
    wr(T2CF_ADDR_CTRL, 8'h00_00);
    wr(T2CF_ADDR_CNTL, 8'h00_11);
    pulse(2);
    rc("nocap ctrl", T2CF_ADDR_CTRL, 8'h00_00);
    rc("nocap rll", T2CF_ADDR_RLL, 8'h00_CD);
    $display("test capture done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {nrst, tick_hi, tick_lo, capture_evt} = 4'b0000;
    cpu_en = 1'b1;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_wrap16();
    t_split();
    t_capture();
    wrap_up();
  end
endmodule // timer2_control_flags_tb

// >>> core/t2cf_counter.sv
// t2cf_counter: 16-bit / split 8-bit auto-reload counter with capture
// assumes single-cycle tick enables from the clock-source selector
`timescale 1ns/1ps
module t2cf_counter
  import t2cf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // mode
  input  wire logic        split,
  input  wire logic        run,
  input  wire logic        tick_hi,
  input  wire logic        tick_lo,
  input  wire logic        capture,
  // register writes
  input  wire logic        wr_cntl,
  input  wire logic        wr_cnth,
  input  wire logic        wr_rll,
  input  wire logic        wr_rlh,
  input  wire logic [7:0]  wdata,
  // state
  output logic      [15:0] count_r,
  output logic      [15:0] reload_r,
  output t2cf_ovf_t        ovf
);
  // ==========================================================================
  // increment decode
  wire       lo_en    = split ? tick_lo : (run & tick_lo);
  wire       hi_en    = split ? (run & tick_hi) : (lo_en & (count_r[7:0] == T2CF_BYTE_MAX));
  wire       lo_wrap  = lo_en & (count_r[7:0] == T2CF_BYTE_MAX);
  wire       hi_wrap  = hi_en & (count_r[15:8] == T2CF_BYTE_MAX);
  wire [7:0] lo_nxt   = split ? (lo_wrap ? reload_r[7:0] : count_r[7:0] + T2CF_BYTE_ONE)
                              : (hi_wrap ? reload_r[7:0] : count_r[7:0] + T2CF_BYTE_ONE);
  wire [7:0] hi_nxt   = hi_wrap ? reload_r[15:8] : count_r[15:8] + T2CF_BYTE_ONE;
  assign ovf.lo = lo_wrap; // see R5
  assign ovf.hi = hi_wrap; // see R1 see R2
  // ==========================================================================
  // count and reload registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= {T2CF_RESET_BYTE, T2CF_RESET_BYTE};
    end else begin
      if (wr_cntl) count_r[7:0] <= wdata;
      else if (lo_en) count_r[7:0] <= lo_nxt; // see R10 see R11
      if (wr_cnth) count_r[15:8] <= wdata;
      else if (hi_en) count_r[15:8] <= hi_nxt;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reload_r <= {T2CF_RESET_BYTE, T2CF_RESET_BYTE};
    end else if (capture) begin
      reload_r <= count_r; // see R12
    end else begin
      if (wr_rll) reload_r[7:0] <= wdata;
      if (wr_rlh) reload_r[15:8] <= wdata;
    end
  end
endmodule // t2cf_counter

// >>> core/t2cf_pkg.sv
// t2cf_pkg: constants and carriers for the timer 2 control and flag block
// assumes an 8-bit special function register bus on the single system clock
package t2cf_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] T2CF_ADDR_CTRL   = 8'h00_C8;
  localparam logic [7:0] T2CF_ADDR_RLL    = 8'h00_CA;
  localparam logic [7:0] T2CF_ADDR_RLH    = 8'h00_CB;
  localparam logic [7:0] T2CF_ADDR_CNTL   = 8'h00_CC;
  localparam logic [7:0] T2CF_ADDR_CNTH   = 8'h00_CD;
  localparam logic [7:0] T2CF_RESET_BYTE  = 8'h00_00;
  localparam logic [7:0] T2CF_BYTE_MAX    = 8'h00_FF;
  localparam logic [7:0] T2CF_BYTE_ONE    = 8'h00_01;
  // ==========================================================================
  // control register fields
  localparam int T2CF_BIT_HOVF  = 7;
  localparam int T2CF_BIT_LOVF  = 6;
  localparam int T2CF_BIT_LIEN  = 5;
  localparam int T2CF_BIT_CAPEN = 4;
  localparam int T2CF_BIT_SPLIT = 3;
  localparam int T2CF_BIT_RUN   = 2;
  localparam int T2CF_CLKSEL_LO = 0;
  localparam int T2CF_CTRL_BITS = 8;
  localparam logic [2:0] T2CF_BIT_HOVF_IDX = 3'h7;
  localparam logic [2:0] T2CF_BIT_LOVF_IDX = 3'h6;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } t2cf_sfr_req_t;
  typedef struct packed {
    logic hi;
    logic lo;
  } t2cf_ovf_t;
endpackage

// >>> core/t2cf_top.sv
// t2cf_top: timer 2 control register, overflow flags and interrupt request
// assumes cpu-side sfr bus and tick/capture strobes synchronous to mclk
// Operation
// R1: high flag sets when upper byte rolls from 0xFF to 0x00.
// R2: in 16-bit mode high flag sets on 0xFFFF to 0x0000 wrap.
// R3: interrupt pending while high flag set and cpu timer enable set.
// R4: hardware never clears high flag; software writes zero.
// R5: low flag sets on low-byte rollover in both modes; never auto-cleared.
// R6: low interrupt enable adds low flag as interrupt source.
// R7: low overflow interrupts only with both low and cpu enables.
// R8: capture enable selects capture mode; otherwise captures ignored.
// R9: control bits 7..4 placed as documented, reset zero, bit-addressable.
// R10: split bit selects two 8-bit or one 16-bit auto-reload timer.
// R11: run bit gates counting; in split mode only upper byte.
// R12: capture copies count into reload pair and sets high flag.
// R13: hardware set wins over simultaneous software clear.
`timescale 1ns/1ps
module t2cf_top
  import t2cf_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // sfr bus
  input  t2cf_sfr_req_t      sfr_req,
  output logic        [7:0]  sfr_rdata_r,
  // clock sources and capture
  input  wire logic          tick_hi,
  input  wire logic          tick_lo,
  input  wire logic          capture_evt,
  // cpu interrupt enable bit
  input  wire logic          cpu_timer_irq_en,
  // outputs
  output logic               irq_r,
  output logic        [1:0]  external_clock_select_r
);
  // ==========================================================================
  // control register
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [15:0] count_w;
  logic [15:0] reload_w;
  t2cf_ovf_t   ovf;

  wire hit_ctrl   = sfr_req.addr == T2CF_ADDR_CTRL;
  wire byte_wr    = sfr_req.wr & hit_ctrl;
  wire bitw       = sfr_req.bit_wr & hit_ctrl;
  wire cap_go     = capture_evt & ctrl_r[T2CF_BIT_CAPEN]; // see R8
  wire set_hi     = ovf.hi | cap_go; // see R12
  wire set_lo     = ovf.lo;
  wire [7:0] bit_mask = T2CF_BYTE_ONE << sfr_req.bit_idx;
  wire [7:0] wr_val   = byte_wr ? sfr_req.wdata
                      : ((ctrl_r & ~bit_mask) | (sfr_req.wdata[0] ? bit_mask : 8'h00_00));
  wire [7:0] base_val = (byte_wr | bitw) ? wr_val : ctrl_r; // see R9
  wire hi_keep = base_val[T2CF_BIT_HOVF] | set_hi; // see R4 see R13
  wire lo_keep = base_val[T2CF_BIT_LOVF] | set_lo; // see R5 see R13

  always_comb begin
    ctrl_nxt                = base_val;
    ctrl_nxt[T2CF_BIT_HOVF] = hi_keep;
    ctrl_nxt[T2CF_BIT_LOVF] = lo_keep;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ctrl_r <= T2CF_RESET_BYTE;
    else ctrl_r <= ctrl_nxt;
  end
  // ==========================================================================
  // counter datapath
  t2cf_counter t2cf_counter_i (
    .mclk     (mclk),
    .nrst     (nrst),
    .split    (ctrl_r[T2CF_BIT_SPLIT]),
    .run      (ctrl_r[T2CF_BIT_RUN]),
    .tick_hi  (tick_hi),
    .tick_lo  (tick_lo),
    .capture  (cap_go),
    .wr_cntl  (sfr_req.wr & (sfr_req.addr == T2CF_ADDR_CNTL)),
    .wr_cnth  (sfr_req.wr & (sfr_req.addr == T2CF_ADDR_CNTH)),
    .wr_rll   (sfr_req.wr & (sfr_req.addr == T2CF_ADDR_RLL)),
    .wr_rlh   (sfr_req.wr & (sfr_req.addr == T2CF_ADDR_RLH)),
    .wdata    (sfr_req.wdata),
    .count_r  (count_w),
    .reload_r (reload_w),
    .ovf      (ovf)
  );
  // ==========================================================================
  // interrupt and read-back
  wire irq_nxt = cpu_timer_irq_en &
                 (ctrl_nxt[T2CF_BIT_HOVF] |
                  (ctrl_nxt[T2CF_BIT_LIEN] & ctrl_nxt[T2CF_BIT_LOVF])); // see R3 see R6 see R7
  wire [7:0] rd_nxt = (sfr_req.addr == T2CF_ADDR_CTRL) ? ctrl_nxt :
                      (sfr_req.addr == T2CF_ADDR_RLL)  ? reload_w[7:0] :
                      (sfr_req.addr == T2CF_ADDR_RLH)  ? reload_w[15:8] :
                      (sfr_req.addr == T2CF_ADDR_CNTL) ? count_w[7:0] :
                      (sfr_req.addr == T2CF_ADDR_CNTH) ? count_w[15:8] : T2CF_RESET_BYTE;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r                   <= 1'b0;
      sfr_rdata_r             <= T2CF_RESET_BYTE;
      external_clock_select_r <= 2'h0;
    end else begin
      irq_r                   <= irq_nxt;
      sfr_rdata_r             <= rd_nxt;
      external_clock_select_r <= ctrl_nxt[T2CF_CLKSEL_LO +: 2];
    end
  end
  // ==========================================================================
  // assertions
  a_hi_ovf_sets: assert property (@(posedge mclk) disable iff (!nrst)
    ovf.hi |=> ctrl_r[T2CF_BIT_HOVF]) else $error("high flag missed overflow"); // see R1
  a_full_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    (!ctrl_r[T2CF_BIT_SPLIT] && ctrl_r[T2CF_BIT_RUN] && tick_lo && count_w == 16'hFFFF
     && !sfr_req.wr && !cap_go) |=> (ctrl_r[T2CF_BIT_HOVF] && count_w == reload_w))
    else $error("16-bit wrap wrong"); // see R2
  a_irq_high: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(cpu_timer_irq_en) && ctrl_r[T2CF_BIT_HOVF]) |-> irq_r)
    else $error("irq not pending with high flag"); // see R3
  a_hi_sticky: assert property (@(posedge mclk) disable iff (!nrst)
    (ctrl_r[T2CF_BIT_HOVF] && !byte_wr && !bitw) |=> ctrl_r[T2CF_BIT_HOVF])
    else $error("high flag cleared by hardware"); // see R4
  a_lo_sets: assert property (@(posedge mclk) disable iff (!nrst)
    ovf.lo |=> ctrl_r[T2CF_BIT_LOVF]) else $error("low flag missed overflow"); // see R5
  a_lo_irq: assert property (@(posedge mclk) disable iff (!nrst)
    (irq_r && !ctrl_r[T2CF_BIT_HOVF]) |-> (ctrl_r[T2CF_BIT_LIEN] && ctrl_r[T2CF_BIT_LOVF]))
    else $error("low irq without enables"); // see R6 see R7
  a_cap_off: assert property (@(posedge mclk) disable iff (!nrst)
    (!ctrl_r[T2CF_BIT_CAPEN] && !sfr_req.wr) |=> $stable(reload_w))
    else $error("reload moved without capture"); // see R8
  a_cap_copy: assert property (@(posedge mclk) disable iff (!nrst)
    cap_go |=> (reload_w == $past(count_w) && ctrl_r[T2CF_BIT_HOVF]))
    else $error("capture copy wrong"); // see R12
  a_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
    (set_lo && byte_wr && !sfr_req.wdata[T2CF_BIT_LOVF]) |=> ctrl_r[T2CF_BIT_LOVF])
    else $error("clear beat set"); // see R13
  a_split_run: assert property (@(posedge mclk) disable iff (!nrst)
    (ctrl_r[T2CF_BIT_SPLIT] && !ctrl_r[T2CF_BIT_RUN] && !sfr_req.wr) |=> $stable(count_w[15:8]))
    else $error("upper byte ran while stopped"); // see R10 see R11
  c_hi_irq: cover property (@(posedge mclk) disable iff (!nrst) ovf.hi ##1 irq_r);
  c_lo_irq: cover property (@(posedge mclk) disable iff (!nrst)
    ovf.lo && ctrl_r[T2CF_BIT_LIEN] ##1 irq_r);
  c_capture: cover property (@(posedge mclk) disable iff (!nrst) cap_go);
  c_split_lo: cover property (@(posedge mclk) disable iff (!nrst)
    ctrl_r[T2CF_BIT_SPLIT] && ovf.lo);
  c_set_wins: cover property (@(posedge mclk) disable iff (!nrst)
    set_lo && byte_wr);
  // ==========================================================================
  // assertions: register access, interrupts, counting and capture
  a_lo_sticky: assert property (@(posedge mclk) disable iff (!nrst) // see R5
    (ctrl_r[T2CF_BIT_LOVF] && !byte_wr && !bitw)
    |=> ctrl_r[T2CF_BIT_LOVF])
    else $error("low flag cleared by hardware");
  a_hi_set_wins: assert property (@(posedge mclk) disable iff (!nrst) // see R13
    (set_hi && byte_wr && !sfr_req.wdata[T2CF_BIT_HOVF])
    |=> ctrl_r[T2CF_BIT_HOVF])
    else $error("clear beat high set");
  a_bit_set_wins: assert property (@(posedge mclk) disable iff (!nrst) // see R13
    (set_lo && bitw && sfr_req.bit_idx == T2CF_BIT_LOVF_IDX)
    |=> ctrl_r[T2CF_BIT_LOVF])
    else $error("bit clear beat low set");
  a_byte_write: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    (byte_wr && !set_hi && !set_lo)
    |=> (ctrl_r == $past(sfr_req.wdata)))
    else $error("control byte write wrong");
  a_bit_others: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    (bitw && !set_hi && !set_lo)
    |=> ((ctrl_r & ~$past(bit_mask)) == ($past(ctrl_r) & ~$past(bit_mask))))
    else $error("bit write touched other bits");
  a_bit_value: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    (bitw && !set_hi && !set_lo)
    |=> (((ctrl_r & $past(bit_mask)) != T2CF_RESET_BYTE) == $past(sfr_req.wdata[0])))
    else $error("bit write value wrong");
  a_clksel_copy: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    external_clock_select_r
    == ctrl_r[T2CF_CLKSEL_LO +: 2])
    else $error("clock select output differs");
  a_rd_ctrl: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    hit_ctrl
    |=> (sfr_rdata_r == ctrl_r))
    else $error("control read-back wrong");
  a_rd_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
    (sfr_req.addr == 8'h00_C9)
    |=> (sfr_rdata_r == T2CF_RESET_BYTE))
    else $error("unmapped read not zero");
  a_rd_count: assert property (@(posedge mclk) disable iff (!nrst)
    (sfr_req.addr == T2CF_ADDR_CNTL)
    |=> (sfr_rdata_r == $past(count_w[7:0])))
    else $error("count low read-back wrong");
  a_irq_level: assert property (@(posedge mclk) disable iff (!nrst) // see R3 see R6 see R7
    irq_r == ($past(cpu_timer_irq_en) && (ctrl_r[T2CF_BIT_HOVF]
      || (ctrl_r[T2CF_BIT_LIEN] && ctrl_r[T2CF_BIT_LOVF]))))
    else $error("irq level wrong");
  a_irq_drop: assert property (@(posedge mclk) disable iff (!nrst) // see R7
    !cpu_timer_irq_en
    |=> !irq_r)
    else $error("irq without cpu enable");
  a_lo_irq_src: assert property (@(posedge mclk) disable iff (!nrst) // see R6
    (cpu_timer_irq_en && ctrl_r[T2CF_BIT_LIEN] && ctrl_r[T2CF_BIT_LOVF] && !byte_wr && !bitw)
    |=> irq_r)
    else $error("low flag irq missing");
  a_stop_16: assert property (@(posedge mclk) disable iff (!nrst) // see R11
    (!ctrl_r[T2CF_BIT_SPLIT] && !ctrl_r[T2CF_BIT_RUN] && !sfr_req.wr)
    |=> $stable(count_w))
    else $error("16-bit counter ran while stopped");
  a_lo_free: assert property (@(posedge mclk) disable iff (!nrst) // see R11
    (ctrl_r[T2CF_BIT_SPLIT] && tick_lo && count_w[7:0] != T2CF_BYTE_MAX && !sfr_req.wr)
    |=> (count_w[7:0] == $past(count_w[7:0]) + T2CF_BYTE_ONE))
    else $error("split low byte did not count");
  a_lo_wrap_split: assert property (@(posedge mclk) disable iff (!nrst) // see R5 see R10
    (ctrl_r[T2CF_BIT_SPLIT] && tick_lo && count_w[7:0] == T2CF_BYTE_MAX && !sfr_req.wr && !cap_go)
    |=> (count_w[7:0] == reload_w[7:0] && ctrl_r[T2CF_BIT_LOVF]))
    else $error("split low wrap wrong");
  a_hi_wrap_split: assert property (@(posedge mclk) disable iff (!nrst) // see R1 see R10
    (ctrl_r[T2CF_BIT_SPLIT] && ctrl_r[T2CF_BIT_RUN] && tick_hi
      && count_w[15:8] == T2CF_BYTE_MAX && !sfr_req.wr && !cap_go)
    |=> (count_w[15:8] == reload_w[15:8] && ctrl_r[T2CF_BIT_HOVF]))
    else $error("split high wrap wrong");
  a_lo_16_carry: assert property (@(posedge mclk) disable iff (!nrst) // see R2
    (!ctrl_r[T2CF_BIT_SPLIT] && ctrl_r[T2CF_BIT_RUN] && tick_lo && !sfr_req.wr
      && count_w[7:0] == T2CF_BYTE_MAX && count_w[15:8] != T2CF_BYTE_MAX)
    |=> (count_w[15:8] == $past(count_w[15:8]) + T2CF_BYTE_ONE))
    else $error("16-bit carry wrong");
  a_cap_ignored: assert property (@(posedge mclk) disable iff (!nrst) // see R8
    (capture_evt && !ctrl_r[T2CF_BIT_CAPEN] && !ovf.hi && !byte_wr && !bitw)
    |=> (ctrl_r[T2CF_BIT_HOVF] == $past(ctrl_r[T2CF_BIT_HOVF])))
    else $error("disabled capture set flag");
  a_cap_beats_wr: assert property (@(posedge mclk) disable iff (!nrst) // see R12
    (cap_go && sfr_req.wr)
    |=> (reload_w == $past(count_w)))
    else $error("reload write beat capture");
endmodule // t2cf_top
